// File: rtl/cnb_pkg.sv
// constants shared by the boot and configuration object group
package cnb_pkg;

  // ----------------------------------------------------------------
  // object indices and subindices
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_PROG_CONTROL = 16'h1F51;
  localparam logic [15:0] IDX_PROG_STATUS = 16'h1F57;
  localparam logic [15:0] IDX_STARTUP = 16'h1F80;
  localparam logic [15:0] IDX_BIT_RATE = 16'h2005;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRMWARE = 8'h01;
  localparam logic [7:0] SUB_SCRIPT = 8'h02;
  localparam logic [7:0] SUB_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam int NUM_AREAS = 2;
  localparam logic [7:0] AREA_COUNT = 8'h02;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] STARTUP_RESET = 32'h0000_0000;
  localparam logic [7:0] BIT_RATE_RESET = 8'h88;
  localparam int STARTUP_OPER_BIT = 3;

  // ----------------------------------------------------------------
  // bit-rate codes and rates in kBd
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_10K = 8'h81;
  localparam logic [7:0] CODE_20K = 8'h82;
  localparam logic [7:0] CODE_50K = 8'h83;
  localparam logic [7:0] CODE_125K = 8'h84;
  localparam logic [7:0] CODE_250K = 8'h85;
  localparam logic [7:0] CODE_500K = 8'h86;
  localparam logic [7:0] CODE_1000K = 8'h88;
  localparam logic [10:0] KBD_10 = 11'h00A;
  localparam logic [10:0] KBD_20 = 11'h014;
  localparam logic [10:0] KBD_50 = 11'h032;
  localparam logic [10:0] KBD_125 = 11'h07D;
  localparam logic [10:0] KBD_250 = 11'h0FA;
  localparam logic [10:0] KBD_500 = 11'h1F4;
  localparam logic [10:0] KBD_1000 = 11'h3E8;

  // ----------------------------------------------------------------
  // network-management states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CNB_NMT_INIT,
    CNB_NMT_PRE_OPERATIONAL,
    CNB_NMT_OPERATIONAL
  } cnb_nmt_t;

endpackage : cnb_pkg

// File: rtl/cnb_rate_decode.sv
// bit-rate selector code to rate in kBd
`timescale 1ns/1ps
`default_nettype none
module cnb_rate_decode (
  input wire logic [7:0] code_in,
  output logic [10:0] kbd_out,
  output logic listed_out
);

  // unknown codes fall back to the fastest rate
  always_comb begin
    listed_out = 1'b1;
    unique case (code_in)
      cnb_pkg::CODE_10K: kbd_out = cnb_pkg::KBD_10;
      cnb_pkg::CODE_20K: kbd_out = cnb_pkg::KBD_20;
      cnb_pkg::CODE_50K: kbd_out = cnb_pkg::KBD_50;
      cnb_pkg::CODE_125K: kbd_out = cnb_pkg::KBD_125;
      cnb_pkg::CODE_250K: kbd_out = cnb_pkg::KBD_250;
      cnb_pkg::CODE_500K: kbd_out = cnb_pkg::KBD_500;
      cnb_pkg::CODE_1000K: kbd_out = cnb_pkg::KBD_1000;
      default: begin
        kbd_out = cnb_pkg::KBD_1000;
        listed_out = 1'b0;
      end
    endcase
  end

endmodule : cnb_rate_decode
`default_nettype wire

// File: rtl/cnb_objects.sv
// boot control, program status, startup and bit-rate object group
//
// How it works
// - two 8-bit area control entries, count 2
// - two 32-bit read-only area status words
// - startup selector picks pre-operational or operational
// - startup selector 32-bit read/write, reset zero
// - bit-rate codes 81h..86h and 88h map to rates
// - unlisted bit-rate code means 1000 kBd
// - bit-rate selector 8-bit read/write, reset 88h
`timescale 1ns/1ps
`default_nettype none
module cnb_objects #(
  parameter int NUM_AREAS = cnb_pkg::NUM_AREAS
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [15:0] index_in,
  input wire logic [7:0] subindex_in,
  input wire logic [31:0] wdata_in,
  input wire logic init_in,
  input wire logic [NUM_AREAS-1:0] area_busy_in,
  input wire logic [NUM_AREAS*32-1:0] area_progress_in,
  output logic ack_out,
  output logic abort_out,
  output logic [31:0] rdata_out,
  output logic [NUM_AREAS*8-1:0] area_control_out,
  output cnb_pkg::cnb_nmt_t nmt_state_out,
  output logic [10:0] bit_rate_kbd_out,
  output logic bit_rate_listed_out
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] area_control [NUM_AREAS];
  logic [31:0] area_program_status [NUM_AREAS];
  logic [31:0] startup_state_select;
  logic [7:0] bus_bit_rate_select;

  // ----------------------------------------------------------------
  // object decode
  // ----------------------------------------------------------------
  wire hit_ctrl = index_in == cnb_pkg::IDX_PROG_CONTROL;
  wire hit_stat = index_in == cnb_pkg::IDX_PROG_STATUS;
  wire hit_start = index_in == cnb_pkg::IDX_STARTUP;
  wire hit_rate = index_in == cnb_pkg::IDX_BIT_RATE;
  wire sub_count = subindex_in == cnb_pkg::SUB_COUNT;
  wire sub_fw = subindex_in == cnb_pkg::SUB_FIRMWARE;
  wire sub_js = subindex_in == cnb_pkg::SUB_SCRIPT;
  wire sub_val = subindex_in == cnb_pkg::SUB_VALUE;
  wire sub_area = sub_fw | sub_js;
  wire area_sel = sub_js;
  wire area_array = hit_ctrl | hit_stat;
  // entry count is readable on both arrays, never writable
  wire rd_count = area_array & sub_count;
  wire rd_ctrl = hit_ctrl & sub_area;
  wire rd_stat = hit_stat & sub_area;
  wire rd_start = hit_start & sub_val;
  wire rd_rate = hit_rate & sub_val;
  wire readable = rd_count | rd_ctrl | rd_stat | rd_start | rd_rate;
  // status words and counts refuse writes
  wire writable = rd_ctrl | rd_start | rd_rate;
  wire legal = write_in ? writable : readable;
  wire do_write = req_in & write_in & writable;
  wire wr_ctrl = do_write & hit_ctrl;
  wire wr_start = do_write & hit_start;
  wire wr_rate = do_write & hit_rate;

  wire [31:0] read_mux =
    rd_count ? {24'h00_0000, cnb_pkg::AREA_COUNT} :
    rd_ctrl ? {24'h00_0000, area_control[area_sel]} :
    rd_stat ? area_program_status[area_sel] :
    rd_start ? startup_state_select :
    rd_rate ? {24'h00_0000, bus_bit_rate_select} :
    32'h0000_0000;

  wire [31:0] next_rdata = (req_in & ~write_in & readable) ?
    read_mux : 32'h0000_0000;

  // ----------------------------------------------------------------
  // bit-rate decode
  // ----------------------------------------------------------------
  logic [10:0] sel_kbd;
  logic sel_listed;

  cnb_rate_decode u_rate (
    .code_in(bus_bit_rate_select),
    .kbd_out(sel_kbd),
    .listed_out(sel_listed)
  );

  // startup choice looks only at the operational bit
  wire start_oper = startup_state_select[cnb_pkg::STARTUP_OPER_BIT];
  wire cnb_pkg::cnb_nmt_t next_nmt = start_oper ?
    cnb_pkg::CNB_NMT_OPERATIONAL : cnb_pkg::CNB_NMT_PRE_OPERATIONAL;

  // ----------------------------------------------------------------
  // per-area control and status
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_AREAS; g++) begin : g_area
      wire this_area = (g == 0) ? sub_fw : sub_js;

      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          area_control[g] <= cnb_pkg::CONTROL_RESET;
        end else if (wr_ctrl && this_area) begin
          area_control[g] <= wdata_in[7:0];
        end
      end

      // progress is tracked only while the area is being programmed
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          area_program_status[g] <= cnb_pkg::STATUS_RESET;
        end else if (area_busy_in[g]) begin
          area_program_status[g] <= area_progress_in[g*32 +: 32];
        end
      end

      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          area_control_out[g*8 +: 8] <= cnb_pkg::CONTROL_RESET;
        end else if (wr_ctrl && this_area) begin
          area_control_out[g*8 +: 8] <= wdata_in[7:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // startup and bit-rate selectors
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      startup_state_select <= cnb_pkg::STARTUP_RESET;
    end else if (wr_start) begin
      startup_state_select <= wdata_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bus_bit_rate_select <= cnb_pkg::BIT_RATE_RESET;
    end else if (wr_rate) begin
      bus_bit_rate_select <= wdata_in[7:0];
    end
  end

  // ----------------------------------------------------------------
  // initialization effects
  // ----------------------------------------------------------------
  // the live rate only moves at init so an active bus is not upset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bit_rate_kbd_out <= cnb_pkg::KBD_1000;
      bit_rate_listed_out <= 1'b1;
    end else if (init_in) begin
      bit_rate_kbd_out <= sel_kbd;
      bit_rate_listed_out <= sel_listed;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      nmt_state_out <= cnb_pkg::CNB_NMT_INIT;
    end else if (init_in) begin
      nmt_state_out <= next_nmt;
    end
  end

  // ----------------------------------------------------------------
  // access answer, one cycle after the request
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      abort_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
    end else begin
      ack_out <= req_in;
      abort_out <= req_in & ~legal;
      rdata_out <= next_rdata;
    end
  end

endmodule : cnb_objects
`default_nettype wire

// File: tb/cnb_objects_checker.sv
// port assertions for the object group
`timescale 1ns/1ps
`default_nettype none
module cnb_objects_checker #(
  parameter int NUM_AREAS = 2
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [15:0] index_in,
  input wire logic [7:0] subindex_in,
  input wire logic [31:0] wdata_in,
  input wire logic init_in,
  input wire logic ack_out,
  input wire logic abort_out,
  input wire logic [31:0] rdata_out,
  input wire logic [NUM_AREAS*8-1:0] area_control_out,
  input wire cnb_pkg::cnb_nmt_t nmt_state_out,
  input wire logic [10:0] bit_rate_kbd_out,
  input wire logic bit_rate_listed_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire logic wr = req_in && write_in;
  wire logic ctl = wr && index_in == 16'h1F51;
  AST_NO_ACK: assert property (!req_in |=> !ack_out)
    else $error("ack without request");
  AST_ACK_REQ: assert property (req_in |=> ack_out)
    else $error("request not answered");
  AST_CTRL_WR: assert property (ctl && subindex_in == 8'h01 |=>
    ack_out && !abort_out && area_control_out[7:0] == $past(wdata_in[7:0]))
    else $error("control write lost");
  AST_CTRL_HOLD: assert property (!ctl |=> $stable(area_control_out))
    else $error("control changed");
  AST_STAT_RO: assert property (wr && index_in == 16'h1F57 |=>
    ack_out && abort_out) else $error("status write taken");
  AST_NMT_INIT: assert property (init_in |=>
    nmt_state_out != cnb_pkg::CNB_NMT_INIT) else $error("no nmt state");
  AST_NMT_HOLD: assert property (!init_in |=> $stable(nmt_state_out))
    else $error("nmt changed");
  AST_START_RW: assert property (req_in && index_in == 16'h1F80 &&
    subindex_in == 8'h00 |=> !abort_out) else $error("startup refused");
  AST_LISTED: assert property (!bit_rate_listed_out |->
    bit_rate_kbd_out == 11'h3E8) else $error("fallback rate wrong");
  AST_RATE_RD: assert property (req_in && !write_in &&
    index_in == 16'h2005 && subindex_in == 8'h00 |=>
    !abort_out && rdata_out[31:8] == 24'h000000) else $error("rate read");
  AST_RATE_HOLD: assert property (!init_in |=>
    $stable(bit_rate_kbd_out)) else $error("rate changed");
endmodule : cnb_objects_checker
bind cnb_objects cnb_objects_checker #(.NUM_AREAS(NUM_AREAS)) chk_i (
  .clock_in(clock_in), .rst_in(rst_in), .req_in(req_in),
  .write_in(write_in), .index_in(index_in), .subindex_in(subindex_in),
  .wdata_in(wdata_in), .init_in(init_in), .ack_out(ack_out),
  .abort_out(abort_out), .rdata_out(rdata_out),
  .area_control_out(area_control_out), .nmt_state_out(nmt_state_out),
  .bit_rate_kbd_out(bit_rate_kbd_out),
  .bit_rate_listed_out(bit_rate_listed_out));
`default_nettype wire

// File: tb/cnb_master_model.sv
// network master model issuing one object access at a time
`timescale 1ns/1ps
`default_nettype none
module cnb_master_model (
  input wire logic clock_in,
  input wire logic ack_in,
  input wire logic abort_in,
  input wire logic [31:0] rdata_in,
  output logic req_out = 1'b0,
  output logic write_out = 1'b0,
  output logic [15:0] index_out = 16'h0000,
  output logic [7:0] subindex_out = 8'h00,
  output logic [31:0] wdata_out = 32'h0
);
  logic got_ack, got_abort;
  logic [31:0] got_rdata;
  task automatic access(input logic w, input logic [15:0] i,
                        input logic [7:0] s, input logic [31:0] d);
    @(negedge clock_in);
    req_out = 1'b1;
    write_out = w;
    index_out = i;
    subindex_out = s;
    wdata_out = d;
    // the answer stands only from the taking edge to the
    // next one, so it is taken at mid-cycle, before anything is released
    @(negedge clock_in);
    got_ack = ack_in;
    got_abort = abort_in;
    got_rdata = rdata_in;
    // released fields show garbage so a stale latch cannot pass
    req_out = 1'b0;
    index_out = ~i;
    subindex_out = ~s;
    wdata_out = ~d;
  endtask : access
endmodule : cnb_master_model
`default_nettype wire

// File: tb/cnb_objects_tb_top.sv
// self-checking bench for the object group
`timescale 1ns/1ps
`default_nettype none
module cnb_objects_tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic init_in = 1'b0;
  logic [1:0] busy = 2'b00;
  logic [63:0] prog = 64'h0;
  logic req, wr, ack, abort, listed;
  logic [15:0] idx, ctrl;
  logic [7:0] sub;
  logic [31:0] wd, rd;
  logic [10:0] kbd;
  cnb_pkg::cnb_nmt_t nmt;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int m_rate = 1000;
  logic [31:0] lfsr = 32'h33B675A8;
  always #50 clock_in = ~clock_in;
  cnb_objects cnb_objects_i (.clock_in(clock_in), .rst_in(rst_in),
    .req_in(req), .write_in(wr), .index_in(idx), .subindex_in(sub),
    .wdata_in(wd), .init_in(init_in), .area_busy_in(busy),
    .area_progress_in(prog), .ack_out(ack), .abort_out(abort),
    .rdata_out(rd), .area_control_out(ctrl), .nmt_state_out(nmt),
    .bit_rate_kbd_out(kbd), .bit_rate_listed_out(listed));
  cnb_master_model cnb_master_model_i (.clock_in(clock_in), .ack_in(ack),
    .abort_in(abort), .rdata_in(rd), .req_out(req), .write_out(wr),
    .index_out(idx), .subindex_out(sub), .wdata_out(wd));
  task automatic complete_run();
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic chk(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] i,
                     input logic [7:0] s, input logic [31:0] d, e,
                     input logic ab);
    cnb_master_model_i.access(w, i, s, d);
    chk("ack", {31'h0, cnb_master_model_i.got_ack}, 32'h1);
    chk("abort", {31'h0, cnb_master_model_i.got_abort}, {31'h0, ab});
    chk("rdata", cnb_master_model_i.got_rdata, e);
  endtask : acc
  int codes[9] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h88, 8'h87,
    8'h00};
  int rates[9] = '{10, 20, 50, 125, 250, 500, 1000, 1000, 1000};
  initial begin
    logic [31:0] d, s;
    repeat (16) @(negedge clock_in);
    rst_in = 1'b0;
    chk("nmt", {30'h0, nmt}, 32'h0);
    acc(1'b0, 16'h1F51, 8'h00, 32'h0, 32'h2, 1'b0);
    acc(1'b0, 16'h1F57, 8'h00, 32'h0, 32'h2, 1'b0);
    acc(1'b0, 16'h1F80, 8'h00, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 16'h2005, 8'h00, 32'h0, 32'h88, 1'b0);
    acc(1'b0, 16'h2006, 8'h00, 32'h0, 32'h0, 1'b1);
    for (int a = 1; a < 3; a++) begin
      d = rnd();
      acc(1'b0, 16'h1F51, 8'(a), 32'h0, 32'h0, 1'b0);
      acc(1'b0, 16'h1F57, 8'(a), 32'h0, 32'h0, 1'b0);
      acc(1'b1, 16'h1F51, 8'(a), d, 32'h0, 1'b0);
      acc(1'b0, 16'h1F51, 8'(a), 32'h0, {24'h0, d[7:0]}, 1'b0);
      chk("ctrl", {24'h0, ctrl[8*a-1 -: 8]}, {24'h0, d[7:0]});
      acc(1'b1, 16'h1F57, 8'(a), d, 32'h0, 1'b1);
      acc(1'b1, 16'h1F51, 8'h00, d, 32'h0, 1'b1);
      prog[32*a-1 -: 32] = d;
      busy[a-1] = 1'b1;
      @(negedge clock_in);
      busy[a-1] = 1'b0;
      prog[32*a-1 -: 32] = ~d;
      acc(1'b0, 16'h1F57, 8'(a), 32'h0, d, 1'b0);
    end
    codes[8] = int'(rnd() & 32'h7F);
    for (int k = 0; k < 9; k++) begin
      s = (k % 2) ? 32'h8 : 32'h0;
      acc(1'b1, 16'h2005, 8'h00, 32'(codes[k]), 32'h0, 1'b0);
      acc(1'b1, 16'h1F80, 8'h00, s, 32'h0, 1'b0);
      acc(1'b0, 16'h2005, 8'h00, 32'h0, 32'(codes[k]), 1'b0);
      acc(1'b0, 16'h1F80, 8'h00, 32'h0, s, 1'b0);
      chk("kbd", {21'h0, kbd}, 32'(m_rate));
      @(negedge clock_in);
      init_in = 1'b1;
      @(negedge clock_in);
      init_in = 1'b0;
      m_rate = rates[k];
      chk("kbd", {21'h0, kbd}, 32'(m_rate));
      chk("listed", {31'h0, listed}, (k < 7) ? 32'h1 : 32'h0);
      chk("nmt", {30'h0, nmt}, s[3] ? 32'h2 : 32'h1);
    end
    complete_run();
  end
endmodule : cnb_objects_tb_top
`default_nettype wire
